// File: bor_pkg.sv
// Package for the brown-out reset controller: offsets, fields, timing constants
package bor_pkg;
    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] BOR_OFF_RESET_CONTROL_REG = 8'h00;
    localparam logic [7:0] BOR_OFF_CONFIG = 8'h04;
    localparam logic [7:0] BOR_OFF_STATUS = 8'h08;
    localparam logic [7:0] BOR_OFF_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] BOR_OFF_IRQ_MASK = 8'h10;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BOR_RCR_BROWNOUT_FLAG_BIT = 0;
    localparam int BOR_RCR_POWER_ON_FLAG_BIT = 1;
    localparam int BOR_RCR_SOFT_ENABLE_BIT = 6;
    localparam int BOR_IRQ_BROWNOUT_BIT = 0;
    localparam int BOR_IRQ_RELEASE_BIT = 1;
    localparam int BOR_IRQ_WIDTH = 2;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic BOR_SOFT_ENABLE_RESET = 1'b1;
    localparam logic [1:0] BOR_IRQ_MASK_RESET = 2'h0;
    // ----------------------------------------
    // Enable configuration encodings
    // ----------------------------------------
    localparam logic [1:0] BOR_CFG_DISABLED = 2'h0;
    localparam logic [1:0] BOR_CFG_SOFTWARE = 2'h1;
    localparam logic [1:0] BOR_CFG_SLEEP_OFF = 2'h2;
    localparam logic [1:0] BOR_CFG_ALWAYS_ON = 2'h3;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int BOR_CLK_MHZ = 40;
    localparam int BOR_MIN_DURATION_NS = 200;
    localparam int BOR_MIN_DURATION_CYCLES = (BOR_MIN_DURATION_NS * BOR_CLK_MHZ + 999) / 1000;
    localparam int BOR_POWER_UP_DELAY_US = 65600;
    localparam int BOR_POWER_UP_DELAY_CYCLES = BOR_POWER_UP_DELAY_US * BOR_CLK_MHZ;

    typedef enum logic [1:0] {
        BOR_ST_RUN,
        BOR_ST_QUALIFY,
        BOR_ST_HOLD,
        BOR_ST_DELAY
    } bor_state_t;

    typedef struct packed {
        logic [1:0] enable_config;
        logic [1:0] threshold_select;
        logic delay_enable;
    } bor_cfg_t;
endpackage : bor_pkg

// File: bor_reset_ctrl.sv
// Brown-out reset controller with AHB-Lite register slave
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module bor_reset_ctrl
    import bor_pkg::*;
#(
    parameter int QUAL_CYCLES = BOR_MIN_DURATION_CYCLES,
    parameter int DELAY_CYCLES = BOR_POWER_UP_DELAY_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire bor_cfg_t cfg,
    input wire logic supply_low,
    input wire logic sleep_mode,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [1:0] comparator_threshold,
    output logic comparator_enable,
    output logic device_reset,
    output logic irq
);
    // ----------------------------------------
    // Synchroniser
    // ----------------------------------------
    logic low_meta;
    logic low_sync;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            low_meta <= 1'b0;
            low_sync <= 1'b0;
        end else begin
            low_meta <= supply_low;
            low_sync <= low_meta;
        end
    end

    // ----------------------------------------
    // Detection enable decode
    // ----------------------------------------
    logic soft_enable;
    logic detect_on;
    always_comb begin
        unique case (cfg.enable_config)
            BOR_CFG_DISABLED: detect_on = 1'b0;
            BOR_CFG_SOFTWARE: detect_on = soft_enable;
            BOR_CFG_SLEEP_OFF: detect_on = !sleep_mode;
            BOR_CFG_ALWAYS_ON: detect_on = 1'b1;
        endcase
    end

    // ----------------------------------------
    // Reset sequencer
    // ----------------------------------------
    bor_state_t state;
    bor_state_t next_state;
    logic [31:0] count;
    logic [31:0] next_count;
    logic next_reset;
    logic bor_event;
    logic release_event;
    always_comb begin
        next_state = state;
        next_count = count;
        bor_event = 1'b0;
        release_event = 1'b0;
        unique case (state)
            BOR_ST_RUN: begin
                next_count = 32'h0;
                if (detect_on && low_sync) begin
                    next_state = BOR_ST_QUALIFY;
                end
            end
            BOR_ST_QUALIFY: begin
                next_count = count + 32'h1;
                if (!detect_on || !low_sync) begin
                    next_state = BOR_ST_RUN;
                end else if (count + 32'h1 >= 32'(QUAL_CYCLES)) begin
                    next_state = BOR_ST_HOLD;
                    bor_event = 1'b1;
                end
            end
            BOR_ST_HOLD: begin
                next_count = 32'h0;
                if (!low_sync || !detect_on) begin
                    if (cfg.delay_enable) begin
                        next_state = BOR_ST_DELAY;
                    end else begin
                        next_state = BOR_ST_RUN;
                        release_event = 1'b1;
                    end
                end
            end
            BOR_ST_DELAY: begin
                next_count = count + 32'h1;
                if (low_sync && detect_on) begin
                    next_state = BOR_ST_HOLD;
                    next_count = 32'h0;
                end else if (count + 32'h1 >= 32'(DELAY_CYCLES)) begin
                    next_state = BOR_ST_RUN;
                    release_event = 1'b1;
                end
            end
        endcase
        next_reset = (next_state == BOR_ST_HOLD) || (next_state == BOR_ST_DELAY);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= BOR_ST_RUN;
            count <= 32'h0;
            device_reset <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            device_reset <= next_reset;
        end
    end

    // ----------------------------------------
    // Register address decode
    // ----------------------------------------
    // Registers sit on whole words; only the low address byte takes part
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
        return addr == offset;
    endfunction : reg_hit

    // ----------------------------------------
    // AHB-Lite address phase
    // ----------------------------------------
    logic wr_pend;
    logic [7:0] wr_addr;
    logic next_wr_pend;
    logic [7:0] next_wr_addr;
    logic access;
    logic wr_rcr;
    logic wr_irq_status;
    logic wr_irq_mask;
    always_comb begin
        access = hsel && hready && htrans[1];
        next_wr_pend = access && hwrite;
        next_wr_addr = haddr[7:0];
        // Writes commit in the data phase, when hwdata stands
        wr_rcr = wr_pend && reg_hit(wr_addr, BOR_OFF_RESET_CONTROL_REG);
        wr_irq_status = wr_pend && reg_hit(wr_addr, BOR_OFF_IRQ_STATUS);
        wr_irq_mask = wr_pend && reg_hit(wr_addr, BOR_OFF_IRQ_MASK);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h0;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
        end
    end

    // ----------------------------------------
    // Reset control register
    // ----------------------------------------
    logic brownout_flag;
    logic power_on_flag;
    logic next_soft_enable;
    logic next_brownout_flag;
    logic next_power_on_flag;
    always_comb begin
        next_soft_enable = soft_enable;
        next_brownout_flag = brownout_flag;
        next_power_on_flag = power_on_flag;
        if (wr_rcr) begin
            next_soft_enable = hwdata[BOR_RCR_SOFT_ENABLE_BIT];
            next_brownout_flag = hwdata[BOR_RCR_BROWNOUT_FLAG_BIT];
            next_power_on_flag = hwdata[BOR_RCR_POWER_ON_FLAG_BIT];
        end
        // A brown-out in the same cycle as a write wins
        if (bor_event && detect_on) begin
            next_brownout_flag = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            soft_enable <= BOR_SOFT_ENABLE_RESET;
            brownout_flag <= 1'b0;
            power_on_flag <= 1'b0;
        end else begin
            soft_enable <= next_soft_enable;
            brownout_flag <= next_brownout_flag;
            power_on_flag <= next_power_on_flag;
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    logic [BOR_IRQ_WIDTH-1:0] irq_status;
    logic [BOR_IRQ_WIDTH-1:0] irq_mask;
    logic [BOR_IRQ_WIDTH-1:0] next_irq_status;
    logic [BOR_IRQ_WIDTH-1:0] next_irq_mask;
    logic [BOR_IRQ_WIDTH-1:0] events;
    logic next_irq;
    always_comb begin
        events = '0;
        events[BOR_IRQ_BROWNOUT_BIT] = bor_event;
        events[BOR_IRQ_RELEASE_BIT] = release_event;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        if (wr_irq_mask) begin
            next_irq_mask = hwdata[BOR_IRQ_WIDTH-1:0];
        end
        if (wr_irq_status) begin
            next_irq_status = irq_status & ~hwdata[BOR_IRQ_WIDTH-1:0];
        end
        // Set beats clear so that no event is lost
        next_irq_status = next_irq_status | events;
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_status <= '0;
            irq_mask <= BOR_IRQ_MASK_RESET;
            irq <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            irq <= next_irq;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    logic [31:0] next_hrdata;
    always_comb begin
        next_hrdata = 32'h0;
        if (access && !hwrite) begin
            unique case (haddr[7:0])
                BOR_OFF_RESET_CONTROL_REG: begin
                    next_hrdata[BOR_RCR_SOFT_ENABLE_BIT] =
                        soft_enable && (cfg.enable_config == BOR_CFG_SOFTWARE);
                    next_hrdata[BOR_RCR_BROWNOUT_FLAG_BIT] = brownout_flag;
                    next_hrdata[BOR_RCR_POWER_ON_FLAG_BIT] = power_on_flag;
                end
                BOR_OFF_CONFIG: next_hrdata[4:0] = cfg;
                BOR_OFF_STATUS: next_hrdata[3:0] = {device_reset, low_sync, detect_on, state != BOR_ST_RUN};
                BOR_OFF_IRQ_STATUS: next_hrdata[BOR_IRQ_WIDTH-1:0] = irq_status;
                BOR_OFF_IRQ_MASK: next_hrdata[BOR_IRQ_WIDTH-1:0] = irq_mask;
                default: next_hrdata = 32'h0;
            endcase
        end
    end

    // Zero wait states and an OKAY answer on every transfer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ----------------------------------------
    // Comparator control
    // ----------------------------------------
    // The analog comparator is powered only while detection is enabled
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            comparator_threshold <= 2'h0;
            comparator_enable <= 1'b0;
        end else begin
            comparator_threshold <= cfg.threshold_select;
            comparator_enable <= detect_on;
        end
    end
endmodule : bor_reset_ctrl

// File: bor_comparator_model.sv
// Behavioural model of the analog low-supply comparator
`timescale 1ns/1ps
module bor_comparator_model (
    input wire logic enable,
    input wire logic [1:0] threshold,
    input wire logic [7:0] vdd,
    output logic supply_low
);
    // Unpowered comparator never reports a drop
    assign supply_low = enable && (vdd < (8'h40 + {2'h0, threshold, 4'h0}));
endmodule : bor_comparator_model

// File: bor_reset_ctrl_properties.sv
// Port assertions for the brown-out reset controller
`timescale 1ns/1ps
module bor_reset_ctrl_properties
    import bor_pkg::*;
#(
    parameter int QUAL_CYCLES = 8,
    parameter int DELAY_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rstn,
    input wire bor_cfg_t cfg,
    input wire logic supply_low,
    input wire logic sleep_mode,
    input wire logic [1:0] comparator_threshold,
    input wire logic comparator_enable,
    input wire logic device_reset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_off;
        cfg.enable_config == BOR_CFG_DISABLED |=> !comparator_enable;
    endproperty
    a_off: assert property (p_off) else $error("detect on while off");
    property p_always;
        cfg.enable_config == BOR_CFG_ALWAYS_ON |=> comparator_enable;
    endproperty
    a_always: assert property (p_always) else $error("detect off in always mode");
    property p_sleep;
        cfg.enable_config == BOR_CFG_SLEEP_OFF |=> comparator_enable == !$past(sleep_mode);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep gating wrong");
    property p_thr;
        1'b1 |=> comparator_threshold == $past(cfg.threshold_select);
    endproperty
    a_thr: assert property (p_thr) else $error("threshold wrong");
    property p_qual;
        (supply_low && comparator_enable)[*8] ##1 (supply_low && comparator_enable)[*5] |-> device_reset;
    endproperty
    a_qual: assert property (p_qual) else $error("long drop gave no reset");
    property p_hold;
        device_reset && $past(supply_low, 2) |=> device_reset || !comparator_enable;
    endproperty
    a_hold: assert property (p_hold) else $error("reset left while low");
    property p_quick;
        !device_reset && $rose(supply_low) |=> !device_reset;
    endproperty
    a_quick: assert property (p_quick) else $error("reset without sync");
    property p_delay;
        $fell(device_reset) && cfg.delay_enable && comparator_enable |-> !$past(supply_low, 8) && !$past(supply_low, 16);
    endproperty
    a_delay: assert property (p_delay) else $error("delay too short");
endmodule : bor_reset_ctrl_properties
bind bor_reset_ctrl bor_reset_ctrl_properties #(.QUAL_CYCLES(QUAL_CYCLES), .DELAY_CYCLES(DELAY_CYCLES)) u_props (
    .clk(clk),
    .rstn(rstn),
    .cfg(cfg),
    .supply_low(supply_low),
    .sleep_mode(sleep_mode),
    .comparator_threshold(comparator_threshold),
    .comparator_enable(comparator_enable),
    .device_reset(device_reset)
);

// File: bor_reset_ctrl_tb.sv
// Self-checking bench for the brown-out reset controller
`timescale 1ns/1ps
module bor_reset_ctrl_tb;
    import bor_pkg::*;
    localparam int DLY = 20;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    bor_cfg_t cfg = '0;
    logic sleep_mode = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0] vdd = 8'hff;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, comparator_enable, device_reset, irq, supply_low, seen;
    logic [1:0] comparator_threshold;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    bor_reset_ctrl #(.QUAL_CYCLES(8), .DELAY_CYCLES(DLY)) DUT (.clk(clk), .rstn(rstn), .cfg(cfg),
        .supply_low(supply_low), .sleep_mode(sleep_mode), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .comparator_threshold(comparator_threshold),
        .comparator_enable(comparator_enable), .device_reset(device_reset), .irq(irq));
    bor_comparator_model u_cmp (.enable(comparator_enable), .threshold(comparator_threshold), .vdd(vdd),
        .supply_low(supply_low));
    task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'h1);
        rd = hrdata;
        hsel <= 1'h0;
    endtask : bus
    task rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'h0, 32'h0);
        chk(name, rd, exp);
        chk("hresp", hresp, 32'h0);
    endtask : rdchk
    task drop(input logic [7:0] lvl);
        seen = 1'h0;
        vdd <= lvl;
        repeat (30) begin
            @(posedge clk);
            seen = seen | device_reset;
        end
        vdd <= 8'hff;
        repeat (6) @(posedge clk);
    endtask : drop
    task restart(input bor_cfg_t c);
        @(posedge clk);
        rstn <= 1'h0;
        cfg <= c;
        repeat (12) @(posedge clk);
        rstn <= 1'h1;
    endtask : restart
    task results;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        restart({BOR_CFG_ALWAYS_ON, 2'h0, 1'h1});
        rdchk("rcr", BOR_OFF_RESET_CONTROL_REG, 32'h0);
        bus(BOR_OFF_CONFIG, 1'h1, 32'hff);
        rdchk("config", BOR_OFF_CONFIG, 32'h19);
        rdchk("unmapped", 8'h20, 32'h0);
        bus(BOR_OFF_RESET_CONTROL_REG, 1'h1, 32'h3);
        bus(BOR_OFF_IRQ_MASK, 1'h1, 32'h1);
        vdd <= 8'h00;
        repeat (30) @(posedge clk);
        chk("held", device_reset, 1'h1);
        chk("irq_on", irq, 1'h1);
        vdd <= 8'hff;
        repeat (12) @(posedge clk);
        vdd <= 8'h00;
        repeat (15) @(posedge clk);
        vdd <= 8'hff;
        repeat (DLY) @(posedge clk);
        chk("restarted", device_reset, 1'h1);
        repeat (8) @(posedge clk);
        chk("released", device_reset, 1'h0);
        rdchk("flags", BOR_OFF_RESET_CONTROL_REG, 32'h2);
        rdchk("status", BOR_OFF_STATUS, 32'h2);
        rdchk("irq_stat", BOR_OFF_IRQ_STATUS, 32'h3);
        bus(BOR_OFF_IRQ_STATUS, 1'h1, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq_off", irq, 1'h0);
        rdchk("irq_left", BOR_OFF_IRQ_STATUS, 32'h2);
        restart({BOR_CFG_SOFTWARE, 2'h3, 1'h0});
        rdchk("soft_on", BOR_OFF_RESET_CONTROL_REG, 32'h40);
        bus(BOR_OFF_RESET_CONTROL_REG, 1'h1, 32'h0);
        drop(8'h60);
        chk("soft_clear", seen, 1'h0);
        bus(BOR_OFF_RESET_CONTROL_REG, 1'h1, 32'h40);
        drop(8'h60);
        chk("soft_set", seen, 1'h1);
        chk("no_delay", device_reset, 1'h0);
        restart({BOR_CFG_SLEEP_OFF, 2'h0, 1'h0});
        drop(8'h60);
        chk("above_thr", seen, 1'h0);
        sleep_mode <= 1'h1;
        drop(8'h00);
        chk("sleep", seen, 1'h0);
        sleep_mode <= 1'h0;
        drop(8'h00);
        chk("awake", seen, 1'h1);
        restart({BOR_CFG_DISABLED, 2'h0, 1'h1});
        drop(8'h00);
        chk("disabled", seen, 1'h0);
        results();
    end
endmodule : bor_reset_ctrl_tb
